//--- design/psa_pkg.sv
// package: register map, reset values and timing of the acquisition controller
// How it works
// - peak path attenuator is driven to attenuation 1 or 16
// - level comparator is latched; latched level drives the attenuator switches
// - gain settles two cycles after level sense, inside the 100 ns filter delay
// - one 12-bit converter sample is taken on every 20 MHz sample tick
// - samples are compared as two's complement, -2048 to 2047
// - each stored word carries sample, attenuator bit and sensor range bit
// - triggered capture with host pre-trigger, post-trigger and level registers
// - overload trip sets an interrupt flag toward the host
// - overload trip forces the sensor upper range via the active-low line
// - average converter channels are serialised over I2S to the processor
// - a 32 bit result word from the processor is held for host reads
// - chop period is a whole number of I2S frames, so samples per chop fixed
// - host selects the amplified channel; processor de-chops and filters it
// - processor result strobe sets a results-ready interrupt flag
// - host commands and program words reach the processor through this block
// - sensor presence change sets an interrupt flag
// - complementary chop drive, host-programmed frequency and levels
// - serial bus mode: chop wire clocks, sensor line data, auto-zero enables
// - equaliser is switched on while an EEPROM sensor is in use
// - every rate is a tick derived from the single system clock
package psa_pkg;
    localparam int CLK_MHZ = 250;
    localparam int FILT_DELAY_NS = 100;
    localparam int GAIN_BUDGET_CYC = FILT_DELAY_NS * CLK_MHZ / 1000;
    localparam int SMP_RATE_MHZ = 20;
    localparam int SMP_NUM = 2;
    localparam int SMP_DEN = CLK_MHZ * SMP_NUM / SMP_RATE_MHZ;
    localparam int I2S_TICK_KHZ = 2500;
    localparam int I2S_DEN = CLK_MHZ * 1000 / I2S_TICK_KHZ;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_PRE = 8'h08;
    localparam logic [7:0] A_POST = 8'h0c;
    localparam logic [7:0] A_TRIG = 8'h10;
    localparam logic [7:0] A_CHOPDIV = 8'h14;
    localparam logic [7:0] A_CHOPLVL = 8'h18;
    localparam logic [7:0] A_SBUS = 8'h1c;
    localparam logic [7:0] A_CMD = 8'h20;
    localparam logic [7:0] A_PROG = 8'h24;
    localparam logic [7:0] A_RESULT = 8'h28;
    localparam logic [7:0] A_TRIGADDR = 8'h2c;
    localparam int F_OVL = 0;
    localparam int F_PRES = 1;
    localparam int F_RES = 2;
    localparam logic [11:0] PRE_RST = 12'h100;
    localparam logic [11:0] POST_RST = 12'h300;
    localparam logic [11:0] TRIG_RST = 12'h000;
    localparam logic [7:0] CHOPDIV_RST = 8'h5a;
    localparam logic [7:0] CHOPLVL_RST = 8'h00;
    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b000,
        ACQ_PRE = 3'b001,
        ACQ_WAIT = 3'b010,
        ACQ_POST = 3'b011,
        ACQ_DONE = 3'b100
    } psa_acq_t;
endpackage

//--- design/psa_rate_div.sv
// fractional tick divider: NUM ticks per DEN clocks
`timescale 1ns/1ps
`default_nettype none
module psa_rate_div #(
    parameter int unsigned NUM = 2,
    parameter int unsigned DEN = 25,
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // one-cycle enable
    output logic tick
);
    logic [W-1:0] acc_r;
    logic [W:0] sum;

    // accumulator form keeps the average exact where DEN/NUM is not whole
    assign sum = {1'b0, acc_r} + (W+1)'(NUM);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            acc_r <= '0;
            tick <= 1'b0;
        end
        else if (sum >= (W+1)'(DEN))
        begin
            acc_r <= W'(sum - (W+1)'(DEN));
            tick <= 1'b1;
        end
        else
        begin
            acc_r <= sum[W-1:0];
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- design/psa_acq_ctrl.sv
// acquisition controller: gain, capture, I2S, chop, sensor bus, host regs
`timescale 1ns/1ps
`default_nettype none
module psa_acq_ctrl
    import psa_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peak path
    input wire logic level_over,
    input wire logic [11:0] adc_data,
    output logic atten_16,
    output logic high_gain_switch,
    output logic adc_convert,
    // sample memory write port
    output logic acq_wr_en,
    output logic [ADDR_W-1:0] acq_wr_addr,
    output logic [13:0] acq_wr_data,
    // average path
    input wire logic ovl_trip,
    output logic sensor_range_force_n,
    input wire logic [15:0] avg_ch_a,
    input wire logic [15:0] avg_ch_b,
    output logic i2s_sck,
    output logic i2s_ws,
    output logic i2s_sd,
    // signal processor
    output logic dsp_chan_sel,
    output logic dsp_wr_valid,
    output logic dsp_wr_prog,
    output logic [31:0] dsp_wr_data,
    input wire logic dsp_res_valid,
    input wire logic [31:0] dsp_res_data,
    // sensor side
    input wire logic sens_present,
    output logic chop_p,
    output logic chop_n,
    output logic [7:0] chop_level,
    input wire logic sens_sda_i,
    output logic sens_sda_o,
    output logic sens_sda_oe,
    output logic autozero_bus_en,
    output logic eq_on,
    output logic host_irq
);
    localparam int GAIN_LAT = 2;

    logic smp_en;
    logic bit_en;
    logic eeprom_r;
    logic arm_r;
    logic [11:0] pre_r;
    logic [11:0] post_r;
    logic [11:0] trig_r;
    logic [7:0] chopdiv_r;
    logic scl_r;
    logic sda_low_r;
    logic [2:0] flags_r;
    logic [2:0] flag_set;
    logic [31:0] result_r;
    logic [31:0] rd_nxt;
    logic lvl_latch_r;
    logic pres_prev_r;
    logic signed [11:0] prev_smp_r;
    logic crossing;
    psa_acq_t acq_r;
    logic [11:0] cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] trig_addr_r;
    logic [4:0] bit_cnt_r;
    logic [31:0] sh_r;
    logic frame_end_r;
    logic [7:0] frame_cnt_r;
    logic chop_phase_r;
    logic setup;
    logic wr_acc;
    logic wr_status;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= A_TRIGADDR);
    endfunction

    psa_rate_div #(.NUM(SMP_NUM), .DEN(SMP_DEN), .W(8)) u_smp_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(smp_en)
    );

    psa_rate_div #(.NUM(1), .DEN(I2S_DEN), .W(8)) u_bit_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(bit_en)
    );

    // apb: pready rises with the first access phase cycle, no wait states
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    assign wr_status = wr_acc && (paddr == A_STATUS);

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (paddr == A_CTRL)
            rd_nxt = {29'h0, arm_r, dsp_chan_sel, eeprom_r};
        else if (paddr == A_STATUS)
            rd_nxt = {24'h0, sens_present, acq_r, atten_16, flags_r};
        else if (paddr == A_PRE)
            rd_nxt = {20'h0, pre_r};
        else if (paddr == A_POST)
            rd_nxt = {20'h0, post_r};
        else if (paddr == A_TRIG)
            rd_nxt = {20'h0, trig_r};
        else if (paddr == A_CHOPDIV)
            rd_nxt = {24'h0, chopdiv_r};
        else if (paddr == A_CHOPLVL)
            rd_nxt = {24'h0, chop_level};
        else if (paddr == A_SBUS)
            rd_nxt = {28'h0, sens_sda_i, autozero_bus_en, sda_low_r, scl_r};
        else if (paddr == A_RESULT)
            rd_nxt = result_r;
        else if (paddr == A_TRIGADDR)
            rd_nxt = 32'(trig_addr_r);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !mapped(paddr);
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            eeprom_r <= 1'b0;
            dsp_chan_sel <= 1'b0;
            pre_r <= PRE_RST;
            post_r <= POST_RST;
            trig_r <= TRIG_RST;
            chopdiv_r <= CHOPDIV_RST;
            chop_level <= CHOPLVL_RST;
            scl_r <= 1'b1;
            sda_low_r <= 1'b0;
            autozero_bus_en <= 1'b0;
            eq_on <= 1'b0;
        end
        else if (wr_acc)
        begin
            if (paddr == A_CTRL)
            begin
                eeprom_r <= pwdata[0];
                eq_on <= pwdata[0];
                dsp_chan_sel <= pwdata[1];
            end
            else if (paddr == A_PRE)
                pre_r <= pwdata[11:0];
            else if (paddr == A_POST)
                post_r <= pwdata[11:0];
            else if (paddr == A_TRIG)
                trig_r <= pwdata[11:0];
            else if (paddr == A_CHOPDIV)
                chopdiv_r <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            else if (paddr == A_CHOPLVL)
                chop_level <= pwdata[7:0];
            else if (paddr == A_SBUS)
            begin
                scl_r <= pwdata[0];
                sda_low_r <= pwdata[1];
                autozero_bus_en <= pwdata[2] && eeprom_r;
            end
        end
    end

    // host to processor mailbox, one strobe per write
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dsp_wr_valid <= 1'b0;
            dsp_wr_prog <= 1'b0;
            dsp_wr_data <= 32'h0000_0000;
        end
        else
        begin
            dsp_wr_valid <= wr_acc && (paddr == A_CMD || paddr == A_PROG);
            if (wr_acc && (paddr == A_CMD || paddr == A_PROG))
            begin
                dsp_wr_prog <= (paddr == A_PROG);
                dsp_wr_data <= pwdata;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            result_r <= 32'h0000_0000;
        else if (dsp_res_valid)
            result_r <= dsp_res_data;
    end

    // sticky flags; a set in the clearing cycle wins
    assign flag_set[F_OVL] = ovl_trip;
    assign flag_set[F_PRES] = sens_present ^ pres_prev_r;
    assign flag_set[F_RES] = dsp_res_valid;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            flags_r <= 3'h0;
            pres_prev_r <= 1'b0;
            host_irq <= 1'b0;
            sensor_range_force_n <= 1'b1;
        end
        else
        begin
            pres_prev_r <= sens_present;
            flags_r <= (flags_r & ~(wr_status ? pwdata[2:0] : 3'h0)) | flag_set;
            host_irq <= |flags_r;
            // range stays forced until the host acknowledges the overload
            sensor_range_force_n <= !(ovl_trip || flags_r[F_OVL]);
        end
    end

    // gain: latch the pre-filter comparator, then set the switches
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lvl_latch_r <= 1'b0;
            atten_16 <= 1'b0;
            high_gain_switch <= 1'b1;
        end
        else
        begin
            lvl_latch_r <= level_over;
            atten_16 <= lvl_latch_r;
            high_gain_switch <= !lvl_latch_r;
        end
    end

    // capture: signed crossing of the trigger level
    assign crossing = ($signed(adc_data) >= $signed(trig_r))
        && (prev_smp_r < $signed(trig_r));

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            adc_convert <= 1'b0;
            acq_wr_en <= 1'b0;
            acq_wr_data <= 14'h0000;
            acq_wr_addr <= '0;
            prev_smp_r <= 12'sh000;
        end
        else
        begin
            adc_convert <= smp_en;
            acq_wr_en <= smp_en && (acq_r == ACQ_PRE || acq_r == ACQ_WAIT
                || acq_r == ACQ_POST);
            if (smp_en)
            begin
                prev_smp_r <= $signed(adc_data);
                acq_wr_data <= {!sensor_range_force_n, atten_16, adc_data};
                acq_wr_addr <= addr_r;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            acq_r <= ACQ_IDLE;
            cnt_r <= 12'h000;
            addr_r <= '0;
            trig_addr_r <= '0;
            arm_r <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == A_CTRL && pwdata[2])
                arm_r <= 1'b1;
            if (smp_en && acq_r != ACQ_IDLE && acq_r != ACQ_DONE)
                addr_r <= addr_r + 1'b1;
            case (acq_r)
                ACQ_IDLE, ACQ_DONE:
                begin
                    if (arm_r)
                    begin
                        arm_r <= 1'b0;
                        acq_r <= ACQ_PRE;
                        cnt_r <= 12'h000;
                        addr_r <= '0;
                    end
                end
                ACQ_PRE:
                begin
                    if (smp_en)
                    begin
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r + 12'h001 >= pre_r)
                            acq_r <= ACQ_WAIT;
                    end
                end
                ACQ_WAIT:
                begin
                    if (smp_en && crossing)
                    begin
                        acq_r <= ACQ_POST;
                        trig_addr_r <= addr_r;
                        cnt_r <= 12'h000;
                    end
                end
                ACQ_POST:
                begin
                    if (smp_en)
                    begin
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r + 12'h001 >= post_r)
                            acq_r <= ACQ_DONE;
                    end
                end
                default:
                    acq_r <= ACQ_IDLE;
            endcase
        end
    end

    // i2s: data moves on the falling sck edge, ws leads the msb by one bit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            i2s_sck <= 1'b0;
            i2s_ws <= 1'b0;
            i2s_sd <= 1'b0;
            bit_cnt_r <= 5'h00;
            sh_r <= 32'h0000_0000;
            frame_end_r <= 1'b0;
        end
        else
        begin
            frame_end_r <= 1'b0;
            if (bit_en)
            begin
                i2s_sck <= !i2s_sck;
                if (i2s_sck)
                begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    i2s_ws <= (bit_cnt_r + 5'h01) >= 5'h10;
                    i2s_sd <= sh_r[31];
                    if (bit_cnt_r == 5'h1f)
                    begin
                        sh_r <= {avg_ch_a, avg_ch_b};
                        frame_end_r <= 1'b1;
                    end
                    else
                        sh_r <= {sh_r[30:0], 1'b0};
                end
            end
        end
    end

    // chop: whole frames per half period keeps samples per chop fixed
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            frame_cnt_r <= 8'h00;
            chop_phase_r <= 1'b0;
            chop_p <= 1'b0;
            chop_n <= 1'b1;
            sens_sda_o <= 1'b0;
            sens_sda_oe <= 1'b0;
        end
        else
        begin
            if (frame_end_r)
            begin
                if (frame_cnt_r >= chopdiv_r - 8'h01)
                begin
                    frame_cnt_r <= 8'h00;
                    chop_phase_r <= !chop_phase_r;
                end
                else
                    frame_cnt_r <= frame_cnt_r + 8'h01;
            end
            chop_p <= autozero_bus_en ? scl_r : chop_phase_r;
            chop_n <= autozero_bus_en ? !scl_r : !chop_phase_r;
            sens_sda_o <= 1'b0;
            sens_sda_oe <= autozero_bus_en && sda_low_r;
        end
    end

    sequence s_level_seen;
        $rose(level_over) ##1 lvl_latch_r;
    endsequence

    // tick gap is counted; a long repetition would be slow to check
    logic [3:0] gap_cnt_r;
    logic gap_seen_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            gap_cnt_r <= 4'h0;
            gap_seen_r <= 1'b0;
        end
        else if (smp_en)
        begin
            gap_cnt_r <= 4'h0;
            gap_seen_r <= 1'b1;
        end
        else if (gap_cnt_r != 4'hf)
            gap_cnt_r <= gap_cnt_r + 4'h1;
    end

    a_gain_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_level_seen |=> atten_16 && !high_gain_switch)
        else $error("attenuator late after level sense");

    a_gain_budget: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(level_over) |-> ##[1:GAIN_LAT] atten_16)
        else $error("attenuator not switched in budget");

    a_smp_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gap_seen_r && (smp_en || int'(gap_cnt_r) >= SMP_DEN / SMP_NUM)
            |-> smp_en && int'(gap_cnt_r) >= SMP_DEN / SMP_NUM - 1)
        else $error("sample tick spacing wrong");

    a_word_pack: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acq_wr_en |-> acq_wr_data[11:0] == $past(adc_data)
            && acq_wr_data[12] == $past(atten_16))
        else $error("stored word does not match sample");

    a_trig_post: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acq_r == ACQ_WAIT && smp_en && crossing
            |=> acq_r == ACQ_POST && trig_addr_r == $past(addr_r))
        else $error("trigger not taken");

    a_ovl_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovl_trip |=> flags_r[F_OVL] && !sensor_range_force_n ##1 host_irq)
        else $error("overload not flagged");

    a_ovl_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
        flags_r[F_OVL] |=> !sensor_range_force_n)
        else $error("range force released early");

    a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        flags_r[F_PRES] && !(wr_status && pwdata[F_PRES]) |=> flags_r[F_PRES])
        else $error("flag lost without clear");

    a_pres_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(sens_present) |=> flags_r[F_PRES])
        else $error("presence change not flagged");

    a_res_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dsp_res_valid |=> flags_r[F_RES] && result_r == $past(dsp_res_data))
        else $error("result not held");

    a_chop_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(chop_phase_r) |-> $past(frame_end_r))
        else $error("chop edge off frame boundary");

    a_chop_diff: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chop_p != chop_n)
        else $error("chop drive not complementary");

    a_sda_open: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sens_sda_oe |-> !sens_sda_o && $past(autozero_bus_en))
        else $error("sensor data line driven high");
endmodule
`default_nettype wire

//--- testbench/psa_dsp_model.sv
// signal processor stand-in: answers each command word with one result
`timescale 1ns/1ps
`default_nettype none
module psa_dsp_model #(
    parameter int DLY = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // words from the host side
    input wire logic wr_valid,
    input wire logic wr_prog,
    input wire logic [31:0] wr_data,
    // result back
    output logic res_valid,
    output logic [31:0] res_data
);
    int cnt;
    logic [31:0] hold;
    always @(posedge sys_clk)
    begin
        res_valid <= 1'b0;
        // outside a strobe the bus keeps moving so stale data never matches
        res_data <= ~res_data;
        if (!rst_n)
        begin
            cnt <= 0;
            res_data <= 32'h0;
        end
        else if (wr_valid && !wr_prog)
        begin
            hold <= ~wr_data;
            cnt <= DLY;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            if (cnt == 1)
            begin
                res_valid <= 1'b1;
                res_data <= hold;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/power_sensor_acquisition_ctrl_tb.sv
// testbench: apb registers, gain, overload, presence, mailbox, capture
`timescale 1ns/1ps
`default_nettype none
module power_sensor_acquisition_ctrl_tb;
    import psa_pkg::*;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, chop_level;
    logic [31:0] pwdata, prdata, wr_data, res_data, d;
    logic [11:0] adc_data;
    logic [15:0] avg_a, avg_b, acq_wr_addr;
    logic [13:0] acq_wr_data;
    logic level_over, ovl_trip, force_n, res_valid, sens_present, sda_oe, sda_o, az;
    logic atten_16, hgs, adc_convert, acq_wr_en, sck, ws, sd, chan, wv, wp;
    logic chop_p, chop_n, eq_on, host_irq;
    wire logic sda_i;
    int bad_count, checked, cyc, n;
    logic [32:0] expq[$];
    // data line has a pull-up; only the device pulls it low
    assign sda_i = sda_oe ? 1'b0 : 1'b1;
    psa_acq_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .level_over(level_over), .adc_data(adc_data),
        .atten_16(atten_16), .high_gain_switch(hgs), .adc_convert(adc_convert),
        .acq_wr_en(acq_wr_en), .acq_wr_addr(acq_wr_addr), .acq_wr_data(acq_wr_data),
        .ovl_trip(ovl_trip), .sensor_range_force_n(force_n), .avg_ch_a(avg_a),
        .avg_ch_b(avg_b), .i2s_sck(sck), .i2s_ws(ws), .i2s_sd(sd), .dsp_chan_sel(chan),
        .dsp_wr_valid(wv), .dsp_wr_prog(wp), .dsp_wr_data(wr_data),
        .dsp_res_valid(res_valid), .dsp_res_data(res_data), .sens_present(sens_present),
        .chop_p(chop_p), .chop_n(chop_n), .chop_level(chop_level), .sens_sda_i(sda_i),
        .sens_sda_o(sda_o), .sens_sda_oe(sda_oe), .autozero_bus_en(az), .eq_on(eq_on),
        .host_irq(host_irq));
    psa_dsp_model u_dsp (.sys_clk(sys_clk), .rst_n(rst_n), .wr_valid(wv), .wr_prog(wp),
        .wr_data(wr_data), .res_valid(res_valid), .res_data(res_data));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wt(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk iff pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // read results are judged where they appear, oldest note first
    always @(posedge sys_clk)
        if (psel && penable && pready && !pwrite && expq.size() > 0)
        begin
            chk({31'h0, pslverr}, {31'h0, expq[0][32]});
            chk(prdata, expq[0][31:0]);
            void'(expq.pop_front());
        end
    always @(posedge sys_clk)
    begin
        adc_data <= 12'($urandom);
        avg_a <= 16'($urandom);
        avg_b <= 16'($urandom);
        cyc++;
        if (cyc == 6000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
        {level_over, ovl_trip, sens_present} = '0;
        void'($urandom(32'h7020));
        wt(4);
        rst_n <= 1'b1;
        wt(1);
        chk({30'h0, hgs, force_n}, 32'h3);
        rd(A_PRE, 33'h100);
        rd(A_POST, 33'h300);
        rd(A_TRIG, 33'h0);
        rd(A_CHOPDIV, 33'h5a);
        rd(8'h30, 33'h1_0000_0000);
        rd(8'h02, 33'h1_0000_0000);
        d = {20'h0, 12'($urandom) | 12'h001};
        apb(1'b1, A_PRE, d);
        rd(A_PRE, {1'b0, d});
        $display("test registers done");
        level_over <= 1'b1;
        wt(4);
        chk({30'h0, atten_16, hgs}, 32'h2);
        rd(A_STATUS, 33'h8);
        level_over <= 1'b0;
        wt(4);
        chk({30'h0, atten_16, hgs}, 32'h1);
        $display("test gain done");
        ovl_trip <= 1'b1;
        wt(1);
        ovl_trip <= 1'b0;
        wt(8);
        chk({30'h0, host_irq, force_n}, 32'h2);
        rd(A_STATUS, 33'h1);
        apb(1'b1, A_STATUS, 32'h1);
        wt(3);
        chk({30'h0, host_irq, force_n}, 32'h1);
        $display("test overload done");
        for (n = 1; n >= 0; n--)
        begin
            sens_present <= n[0];
            wt(4);
            chk({31'h0, host_irq}, 32'h1);
            rd(A_STATUS, {25'h0, n[0], 7'h02});
            apb(1'b1, A_STATUS, 32'h2);
            wt(3);
            chk({31'h0, host_irq}, 32'h0);
        end
        $display("test presence done");
        d = $urandom;
        apb(1'b1, A_CMD, d);
        wt(3);
        chk(wr_data, d);
        chk({31'h0, wp}, 32'h0);
        wt(14);
        chk({31'h0, host_irq}, 32'h1);
        rd(A_RESULT, {1'b0, ~d});
        rd(A_STATUS, 33'h4);
        apb(1'b1, A_STATUS, 32'h4);
        apb(1'b1, A_PROG, d);
        wt(3);
        chk({31'h0, wp}, 32'h1);
        wt(14);
        chk({31'h0, host_irq}, 32'h0);
        $display("test mailbox done");
        d = $urandom;
        apb(1'b1, A_CHOPLVL, {24'h0, d[7:0]});
        apb(1'b1, A_CTRL, 32'h3);
        wt(3);
        chk({24'h0, chop_level}, {24'h0, d[7:0]});
        chk({30'h0, eq_on, chan}, 32'h3);
        chk({31'h0, chop_n}, {31'h0, ~chop_p});
        rd(A_CTRL, 33'h3);
        $display("test control done");
        // bus mode: scl high on the chop wire, data pulled low, pull-up elsewhere
        apb(1'b1, A_SBUS, 32'h7);
        wt(2);
        chk({28'h0, chop_p, chop_n, sda_oe, sda_o}, 32'ha);
        rd(A_SBUS, 33'h7);
        apb(1'b1, A_SBUS, 32'h1);
        $display("test sensor bus done");
        apb(1'b1, A_PRE, 32'h2);
        apb(1'b1, A_POST, 32'h4);
        apb(1'b1, A_CTRL, 32'h4);
        for (n = 0; n < 60 && acq_wr_en !== 1'b1; n++)
            @(posedge sys_clk);
        chk({31'h0, acq_wr_en}, 32'h1);
        chk({16'h0, acq_wr_addr}, 32'h0);
        chk({30'h0, acq_wr_data[13:12]}, 32'h0);
        // sck toggles once per 100 clocks; two sample ticks per 25 clocks
        d[0] = sck;
        n = 0;
        repeat (100)
        begin
            @(posedge sys_clk);
            n += int'(adc_convert);
        end
        chk({31'h0, sck}, {31'h0, ~d[0]});
        chk(32'(n), 32'h8);
        // random samples cross level 0 within a few ticks, post is short
        wt(700);
        rd(A_STATUS, 33'h40);
        $display("test capture done");
        wt(4);
        chk(32'(expq.size()), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
